// file: core/ctlrr_pkg.sv
// constants shared by the crt timing generator and its cursor unit
`default_nettype none
package ctlrr_pkg;
    // ------------------------------------------------------------
    // character clock
    // ------------------------------------------------------------
    localparam int CHAR_DIV_DEF = 11;            // 40 MHz / 11, about 3.6 MHz character rate
    // ------------------------------------------------------------
    // counter widths
    // ------------------------------------------------------------
    localparam int HW  = 8;                      // horizontal character counter
    localparam int RW  = 5;                      // raster within a row
    localparam int VW  = 7;                      // character row counter
    localparam int AW  = 14;                     // refresh memory address
    localparam int AHW = 6;                      // high start/cursor address byte
    localparam int SWW = 4;                      // one sync width nibble
    // ------------------------------------------------------------
    // field positions in the packed settings
    // ------------------------------------------------------------
    localparam int HSW_LSB    = 0;               // horizontal sync width nibble
    localparam int VSW_LSB    = 4;               // vertical sync width nibble
    localparam int DSKEW_LSB  = 4;               // display enable skew in scan mode byte
    localparam int CSKEW_LSB  = 6;               // cursor skew in scan mode byte
    localparam int BLINK_LSB  = 5;               // blink mode in cursor first line
    localparam int CSTART_LSB = 0;               // first cursor raster
    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_RST  = 14'h0000;
    localparam logic [4:0]    BLINK_RST = 5'h00;
    localparam logic [4:0]    SW_ZERO_WIDTH = 5'h10;  // zero nibble means sixteen
    // blink modes
    localparam logic [1:0] BLINK_STEADY = 2'h0;
    localparam logic [1:0] BLINK_OFF    = 2'h1;
    localparam logic [1:0] BLINK_FAST   = 2'h2;
    localparam logic [1:0] SKEW_NONE    = 2'h3;  // skew code that suppresses the output
    // vertical sequencer states
    typedef enum logic [1:0] {
        ST_ROWS   = 2'b01,
        ST_ADJUST = 2'b10
    } ctlrr_state_t;
endpackage : ctlrr_pkg
`default_nettype wire

// file: core/ctlrr_cur_if.sv
// link between the timing core and the cursor unit
`default_nettype none
interface ctlrr_cur_if;
    logic       tick_field;   // one pulse per completed field
    logic [4:0] raster;       // raster within current row
    logic       addr_hit;     // memory address equals cursor address in display
    logic [6:0] first_line;   // blink mode and first cursor raster
    logic [4:0] last_line;    // last cursor raster
    logic       cursor_on;    // cursor video before skew
    modport timing (output tick_field, raster, addr_hit, first_line, last_line, input cursor_on);
    modport cursor (input tick_field, raster, addr_hit, first_line, last_line, output cursor_on);
endinterface : ctlrr_cur_if
`default_nettype wire

// file: core/ctlrr_cursor.sv
// cursor raster window and blink counter
`default_nettype none
module ctlrr_cursor
    import ctlrr_pkg::*;
(
    // clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    // link to timing core
    ctlrr_cur_if.cursor cif
);
    logic [4:0] blink;
    logic [4:0] next_blink;
    logic       in_window;
    logic       phase_ok;

    // ------------------------------------------------------------
    // blink counter, one step per field
    // ------------------------------------------------------------
    always_comb begin
        next_blink = blink;
        if (cif.tick_field) begin
            next_blink = 5'(blink + 5'h01);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            blink <= BLINK_RST;
        end else begin
            blink <= next_blink;
        end
    end

    // ------------------------------------------------------------
    // window compares read live settings, so a write in the last
    // character time can make the cursor jitter for a raster
    // ------------------------------------------------------------
    always_comb begin
        in_window = (cif.raster >= cif.first_line[CSTART_LSB +: 5]) &&
                    (cif.raster <= cif.last_line);
        case (cif.first_line[BLINK_LSB +: 2])
            BLINK_STEADY: phase_ok = 1'b1;
            BLINK_OFF:    phase_ok = 1'b0;
            BLINK_FAST:   phase_ok = blink[3];       // 16 field period
            default:      phase_ok = blink[4];       // 32 field period
        endcase
        cif.cursor_on = cif.addr_hit && in_window && phase_ok;
    end
endmodule : ctlrr_cursor
`default_nettype wire

// file: core/ctlrr_timing.sv
// raster crt timing generator that follows live setting rewrites
`default_nettype none
// Overview of operation
// - horizontal total write acts at once
// - shown width write may shorten one enable
// - sync position write may misplace sync
// - width write may cut running pulse short
// - adjust write at line end may skip
// - row count write blanks rest of field
// - raster count written only while idle
// - cursor line write may jitter cursor
// - start address taken at field end
// - split start write gives mixed address
// - cursor address best written in retrace
// - split cursor write gives mixed address
// - new settings fully apply next field
// - first field blank, addresses from zero
module ctlrr_timing
    import ctlrr_pkg::*;
#(
    parameter int CHAR_DIV = CHAR_DIV_DEF
) (
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    // timing settings, driven live by the host
    input  wire logic [ctlrr_pkg::HW-1:0]  i_horiz_total_reg,
    input  wire logic [ctlrr_pkg::HW-1:0]  i_horiz_shown_reg,
    input  wire logic [ctlrr_pkg::HW-1:0]  i_horiz_sync_pos_reg,
    input  wire logic [7:0]                i_sync_pulse_width_reg,
    input  wire logic [ctlrr_pkg::VW-1:0]  i_vert_total_reg,
    input  wire logic [4:0]                i_vert_adjust_reg,
    input  wire logic [ctlrr_pkg::VW-1:0]  i_vert_shown_reg,
    input  wire logic [ctlrr_pkg::VW-1:0]  i_vert_sync_pos_reg,
    input  wire logic [7:0]                i_scan_mode_skew_reg,
    input  wire logic [4:0]                i_rasters_per_row_reg,
    // cursor and origin settings
    input  wire logic [6:0]                i_cursor_first_line_reg,
    input  wire logic [4:0]                i_cursor_last_line_reg,
    input  wire logic [ctlrr_pkg::AHW-1:0] i_origin_addr_high_reg,
    input  wire logic [7:0]                i_origin_addr_low_reg,
    input  wire logic [ctlrr_pkg::AHW-1:0] i_cursor_addr_high_reg,
    input  wire logic [7:0]                i_cursor_addr_low_reg,
    // display and memory outputs
    output logic                           o_display_enable_out,
    output logic                           o_cursor_video_out,
    output logic                           o_hsync,
    output logic                           o_vsync,
    output logic [ctlrr_pkg::AW-1:0]       o_memory_row_address,
    output logic [4:0]                     o_raster_line_address,
    output logic                           o_char_tick
);
    import ctlrr_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CHAR_DIV < 1 || CHAR_DIV > 255) begin : g_bad_div
        $error("CHAR_DIV must lie in 1..255");
    end

    ctlrr_cur_if cif ();

    ctlrr_state_t   state, next_state;
    logic [7:0]     div_cnt, next_div_cnt;
    logic [HW-1:0]  hcnt, next_hcnt;
    logic [RW-1:0]  ras, next_ras;
    logic [VW-1:0]  row, next_row;
    logic [4:0]     adj, next_adj;
    logic [AW-1:0]  ma, next_ma, ma_row, next_ma_row;
    logic [SWW-1:0] hsw_cnt, next_hsw_cnt, vsw_cnt, next_vsw_cnt;
    logic           hsync, next_hsync, vsync, next_vsync;
    logic           vkill, next_vkill, first_field, next_first_field;
    logic [VW-1:0]  vshown_prev;
    logic [2:0]     de_pipe, next_de_pipe, cur_pipe, next_cur_pipe;
    logic           next_de_out, next_cur_out;
    logic           tick, line_end, last_ras, last_row, adj_done, field_end;
    logic           de_raw, row_step;
    logic [4:0]     h_width, v_width;
    logic [AW-1:0]  origin, cursor_addr;

    // zero nibble means the longest pulse of sixteen
    function automatic logic [4:0] sync_width(input logic [SWW-1:0] nib);
        return (nib == 4'h0) ? SW_ZERO_WIDTH : {1'b0, nib};
    endfunction : sync_width

    // picks the undelayed or a delayed copy; the top code blanks the output
    function automatic logic skew_pick(input logic now, input logic [2:0] pipe, input logic [1:0] code);
        case (code)
            2'h0:    return now;
            2'h1:    return pipe[0];
            2'h2:    return pipe[1];
            default: return 1'b0;
        endcase
    endfunction : skew_pick

    // ------------------------------------------------------------
    // live compares; vshown_prev is the one setting copy, kept only to detect a change
    // ------------------------------------------------------------
    always_comb begin
        tick        = (div_cnt == 8'(CHAR_DIV - 1));
        line_end    = (hcnt >= i_horiz_total_reg);
        last_ras    = (ras >= i_rasters_per_row_reg);
        last_row    = (row >= i_vert_total_reg);
        adj_done    = (6'({1'b0, adj} + 6'h01) >= {1'b0, i_vert_adjust_reg});
        row_step    = (state == ST_ROWS) && last_ras;
        // adjust value is read in the last character time only
        field_end   = line_end && ((row_step && last_row && (i_vert_adjust_reg == 5'h00)) ||
                      ((state == ST_ADJUST) && adj_done));
        h_width     = sync_width(i_sync_pulse_width_reg[HSW_LSB +: SWW]);
        v_width     = sync_width(i_sync_pulse_width_reg[VSW_LSB +: SWW]);
        origin      = {i_origin_addr_high_reg, i_origin_addr_low_reg};
        cursor_addr = {i_cursor_addr_high_reg, i_cursor_addr_low_reg};
        de_raw      = (hcnt < i_horiz_shown_reg) && (state == ST_ROWS) &&
                      (row < i_vert_shown_reg) && !vkill;
    end

    // ------------------------------------------------------------
    // divider steps each clock; other counters and sync step once per character time
    // ------------------------------------------------------------
    always_comb begin
        next_div_cnt     = tick ? 8'h00 : 8'(div_cnt + 8'h01);
        next_state       = state;
        next_hcnt        = hcnt;
        next_ras         = ras;
        next_row         = row;
        next_adj         = adj;
        next_ma          = ma;
        next_ma_row      = ma_row;
        next_hsync       = hsync;
        next_hsw_cnt     = hsw_cnt;
        next_vsync       = vsync;
        next_vsw_cnt     = vsw_cnt;
        next_first_field = first_field;
        // a changed row count blanks until the field ends; the change wins
        next_vkill       = vkill;
        if (tick && field_end) begin
            next_vkill = 1'b0;
        end
        if (i_vert_shown_reg != vshown_prev) begin
            next_vkill = 1'b1;
        end
        if (tick) begin
            next_hcnt = line_end ? '0 : 8'(hcnt + 8'h01);
            next_ma   = 14'(ma + 14'h0001);
            if (line_end) begin
                if (field_end) begin
                    // origin is sampled only in the last raster of a field
                    next_ma          = origin;
                    next_ma_row      = origin;
                    next_ras         = '0;
                    next_row         = '0;
                    next_adj         = '0;
                    next_state       = ST_ROWS;
                    next_first_field = 1'b0;
                end else if (row_step) begin
                    next_ma_row = 14'(ma_row + {6'h00, i_horiz_shown_reg});
                    next_ma     = next_ma_row;
                    next_ras    = '0;
                    if (last_row) begin
                        next_state = ST_ADJUST;
                    end else begin
                        next_row = 7'(row + 7'h01);
                    end
                end else begin
                    next_ma = ma_row;
                    if (state == ST_ADJUST) begin
                        next_adj = 5'(adj + 5'h01);
                    end else begin
                        next_ras = 5'(ras + 5'h01);
                    end
                end
            end
            // horizontal sync: start on position, end when the live width is met
            if (hcnt == i_horiz_sync_pos_reg) begin
                next_hsync   = 1'b1;
                next_hsw_cnt = '0;
            end else if (hsync) begin
                next_hsw_cnt = 4'(hsw_cnt + 4'h1);
                if (5'({1'b0, hsw_cnt} + 5'h01) >= h_width) begin
                    next_hsync = 1'b0;
                end
            end
            // vertical sync counted in whole lines
            if ((hcnt == '0) && (ras == '0) && (state == ST_ROWS) &&
                (row == i_vert_sync_pos_reg) && !vsync) begin
                next_vsync   = 1'b1;
                next_vsw_cnt = '0;
            end else if (vsync && line_end) begin
                next_vsw_cnt = 4'(vsw_cnt + 4'h1);
                if (5'({1'b0, vsw_cnt} + 5'h01) >= v_width) begin
                    next_vsync = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // skew pipes and output values; skew bits are trusted static
    // ------------------------------------------------------------
    always_comb begin
        next_de_pipe  = de_pipe;
        next_cur_pipe = cur_pipe;
        next_de_out   = o_display_enable_out;
        next_cur_out  = o_cursor_video_out;
        if (tick) begin
            next_de_pipe  = {de_pipe[1:0], de_raw};
            next_cur_pipe = {cur_pipe[1:0], cif.cursor_on};
            // first field after reset shows neither display nor cursor
            next_de_out   = !first_field &&
                            skew_pick(de_raw, de_pipe, i_scan_mode_skew_reg[DSKEW_LSB +: 2]);
            next_cur_out  = !first_field &&
                            skew_pick(cif.cursor_on, cur_pipe, i_scan_mode_skew_reg[CSKEW_LSB +: 2]);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state                <= ST_ROWS;
            div_cnt              <= 8'h00;
            hcnt                 <= '0;
            ras                  <= '0;
            row                  <= '0;
            adj                  <= '0;
            ma                   <= ADDR_RST;
            ma_row               <= ADDR_RST;
            hsync                <= 1'b0;
            hsw_cnt              <= '0;
            vsync                <= 1'b0;
            vsw_cnt              <= '0;
            vkill                <= 1'b0;
            first_field          <= 1'b1;
            vshown_prev          <= '0;
            de_pipe              <= 3'h0;
            cur_pipe             <= 3'h0;
            o_display_enable_out <= 1'b0;
            o_cursor_video_out   <= 1'b0;
        end else begin
            state                <= next_state;
            div_cnt              <= next_div_cnt;
            hcnt                 <= next_hcnt;
            ras                  <= next_ras;
            row                  <= next_row;
            adj                  <= next_adj;
            ma                   <= next_ma;
            ma_row               <= next_ma_row;
            hsync                <= next_hsync;
            hsw_cnt              <= next_hsw_cnt;
            vsync                <= next_vsync;
            vsw_cnt              <= next_vsw_cnt;
            vkill                <= next_vkill;
            first_field          <= next_first_field;
            vshown_prev          <= i_vert_shown_reg;
            de_pipe              <= next_de_pipe;
            cur_pipe             <= next_cur_pipe;
            o_display_enable_out <= next_de_out;
            o_cursor_video_out   <= next_cur_out;
        end
    end

    // ------------------------------------------------------------
    // cursor unit; address compared live, so retrace writes are safest
    // ------------------------------------------------------------
    assign cif.tick_field = tick && field_end;
    assign cif.raster     = ras;
    assign cif.addr_hit   = de_raw && (ma == cursor_addr);
    assign cif.first_line = i_cursor_first_line_reg;
    assign cif.last_line  = i_cursor_last_line_reg;

    ctlrr_cursor u_cursor (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .cif   (cif.cursor)
    );

    assign o_hsync               = hsync;
    assign o_vsync               = vsync;
    assign o_memory_row_address  = ma;
    assign o_raster_line_address = ras;
    assign o_char_tick           = tick;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_line_wrap: assert property (tick && line_end |=> hcnt == '0)
        else $error("character counter did not wrap at total");
    chk_hsync_start: assert property (tick && (hcnt == i_horiz_sync_pos_reg) |=> o_hsync)
        else $error("hsync missing at sync position");
    chk_hsync_end: assert property (tick && hsync && (hcnt != i_horiz_sync_pos_reg) &&
        (5'({1'b0, hsw_cnt} + 5'h01) >= h_width) |=> !o_hsync)
        else $error("hsync overran width");
    chk_first_blank: assert property (first_field |=> !o_display_enable_out && !o_cursor_video_out)
        else $error("output during first field");
    chk_reset_addr: assert property ($past(i_rst) |-> (ma == '0) && (ras == '0))
        else $error("addresses not zero after reset");
    chk_origin_load: assert property (tick && field_end |=> ma == $past(origin))
        else $error("field did not start at origin");
    chk_adj_skip: assert property (tick && field_end |=> (state == ST_ROWS) && (row == '0) && !first_field)
        else $error("new field not started");
    // only the unskewed path is judged; delayed copies may still carry up to two old characters
    chk_row_blank: assert property (tick && vkill && (i_scan_mode_skew_reg[DSKEW_LSB +: 2] == 2'h0)
        |=> !o_display_enable_out)
        else $error("display not blanked after row count change");
    chk_no_adjust: assert property (tick && line_end && row_step && last_row &&
        (i_vert_adjust_reg == 5'h00) |=> state == ST_ROWS)
        else $error("adjust entered with zero adjust");

    cov_field_end: cover property (tick && field_end && !first_field);
    cov_adjust:    cover property (state == ST_ADJUST);
    cov_vsync:     cover property ($rose(o_vsync));
    cov_cursor:    cover property (o_cursor_video_out);
endmodule : ctlrr_timing
`default_nettype wire

// file: verification/ctlrr_crt_model.sv
// far-side display model: measures line, enable and hsync lengths in characters
`default_nettype none
module ctlrr_crt_model (
    // display side pins
    input  wire logic i_clk,
    input  wire logic i_char_tick,
    input  wire logic i_display_enable,
    input  wire logic i_hsync,
    // figures of the last complete line
    output logic [7:0] o_line_len,
    output logic [7:0] o_en_len,
    output logic [7:0] o_hs_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] n_ch = 8'h00;
    logic [7:0] n_en = 8'h00;
    logic [7:0] n_hs = 8'h00;
    logic       hs_d = 1'b0;
    initial {o_line_len, o_en_len, o_hs_len} = '0;
    // a line runs from one hsync rise to the next; blank lines keep the last enable width
    always @(posedge i_clk) begin
        if (i_char_tick) begin
            hs_d <= i_hsync;
            n_ch <= n_ch + 8'h01;
            n_en <= n_en + 8'(i_display_enable);
            n_hs <= n_hs + 8'(i_hsync);
            if (i_hsync && !hs_d) begin
                o_line_len <= n_ch;
                o_hs_len   <= n_hs;
                if (n_en != 8'h00) o_en_len <= n_en;
                n_ch <= 8'h01;
                n_en <= 8'(i_display_enable);
                n_hs <= 8'h01;
            end
        end
    end
endmodule : ctlrr_crt_model
`default_nettype wire

// file: verification/ctlrr_timing_test.sv
// self-checking bench for the crt timing generator under live rewrites
`default_nettype none
module ctlrr_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ctlrr_pkg::*;
    localparam int DIV = 2;  // short character time keeps fields brief
    // settings driven live
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] htot = 8'h09, hshow = 8'h06, hpos = 8'h07, swid = 8'h12, olow = 8'h00;
    logic [5:0] ohigh = 6'h00;
    logic [7:0] mode = 8'h00;   // fixed while display runs
    logic [4:0] rpr = 5'h01;    // fixed while display runs
    logic [6:0] vtot = 7'h03, vshow = 7'h02, vpos = 7'h03;
    // outputs
    logic de, cur, hs, vs, tick;
    logic [13:0] ma;
    logic [4:0] ra;
    logic [7:0] llen, elen, hlen;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    initial forever #12.5 i_clk = ~i_clk;
    ctlrr_timing #(.CHAR_DIV(DIV)) ctlrr_timing_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_horiz_total_reg(htot), .i_horiz_shown_reg(hshow), .i_horiz_sync_pos_reg(hpos),
        .i_sync_pulse_width_reg(swid), .i_vert_total_reg(vtot), .i_vert_adjust_reg(5'h00),
        .i_vert_shown_reg(vshow), .i_vert_sync_pos_reg(vpos), .i_scan_mode_skew_reg(mode),
        .i_rasters_per_row_reg(rpr), .i_cursor_first_line_reg(7'h00), .i_cursor_last_line_reg(5'h01),
        .i_origin_addr_high_reg(ohigh), .i_origin_addr_low_reg(olow), .i_cursor_addr_high_reg(6'h00),
        .i_cursor_addr_low_reg(8'h21), .o_display_enable_out(de), .o_cursor_video_out(cur),
        .o_hsync(hs), .o_vsync(vs), .o_memory_row_address(ma), .o_raster_line_address(ra), .o_char_tick(tick));
    ctlrr_crt_model ctlrr_crt_model_inst (.i_clk(i_clk), .i_char_tick(tick), .i_display_enable(de),
        .i_hsync(hs), .o_line_len(llen), .o_en_len(elen), .o_hs_len(hlen));
    // -----------------------------------------------
    // shared tasks
    // -----------------------------------------------
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task step(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : step
    // bounded wait for the next vsync rise
    task wait_vsync;
        int k;
        for (k = 0; k < 900 && vs !== 1'b0; k++) step(1);
        for (k = 0; k < 900 && vs !== 1'b1; k++) step(1);
    endtask : wait_vsync
    task tally_and_finish;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // -----------------------------------------------
    // scenarios
    // -----------------------------------------------
    // first field: outputs dark, counting from zero with origin left at zero
    task t_first_field;
        logic seen;
        int k;
        seen = 1'b0;
        check("reset address", 16'h0000, {2'h0, ma});
        check("reset raster", 16'h0000, {11'h000, ra});
        for (k = 0; k < 900 && vs !== 1'b1; k++) begin
            seen = seen | de | cur;
            step(1);
        end
        check("first field dark", 16'h0000, {15'h0000, seen});
    endtask : t_first_field
    // line figures measured by the display model after a full field
    task t_hline(input logic [7:0] l, input logic [7:0] e, input logic [7:0] h);
        wait_vsync();
        wait_vsync();
        check("line length", {8'h00, l}, {8'h00, llen});
        check("enable width", {8'h00, e}, {8'h00, elen});
        check("hsync width", {8'h00, h}, {8'h00, hlen});
    endtask : t_hline
    // lowest address in a field equals the start address taken at field end;
    // the cursor shows only when its address falls inside the shown area
    task t_org(input logic [5:0] hi, input logic [7:0] lo, input logic cur_exp);
        logic [13:0] low_seen;
        logic        cur_seen;
        int k;
        ohigh = hi;
        olow  = lo;
        wait_vsync();
        wait_vsync();
        low_seen = 14'h3FFF;
        cur_seen = 1'b0;
        for (k = 0; k < 900 && !(vs === 1'b1 && k > 40); k++) begin
            if (ma < low_seen) low_seen = ma;
            cur_seen = cur_seen | cur;
            step(1);
        end
        check("origin address", {2'h0, hi, lo}, {2'h0, low_seen});
        check("cursor shown", {15'h0000, cur_exp}, {15'h0000, cur_seen});
    endtask : t_org
    // row count rewrite mid-field: dark till field end, new count next field
    task t_rows;
        logic lit;
        int k, n;
        lit = 1'b0;
        n = 0;
        wait_vsync();
        for (k = 0; k < 900 && de !== 1'b1; k++) step(1);
        vshow = 7'h01;
        step(2 * DIV);  // one character may still leave with the old enable
        for (k = 0; k < 900 && vs !== 1'b1; k++) begin
            lit = lit | de;
            step(1);
        end
        check("rest of field dark", 16'h0000, {15'h0000, lit});
        for (k = 0; k < 900 && vs !== 1'b0; k++) step(1);
        for (k = 0; k < 900 && vs !== 1'b1; k++) begin
            n = n + int'(de === 1'b1);
            step(1);
        end
        // one row of two rasters, four characters each, two clocks a character
        check("next field enable clocks", 16'h0010, 16'(n));
    endtask : t_rows
    // -----------------------------------------------
    // main sequence and hang guard
    // -----------------------------------------------
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        step(10);
        i_rst = 1'b0;
        step(1);
        t_first_field();
        t_hline(8'h0A, 8'h06, 8'h02);
        htot = 8'h0B;
        t_hline(8'h0C, 8'h06, 8'h02);
        hshow = 8'h04;
        hpos  = 8'h05;
        swid  = 8'h13;
        t_hline(8'h0C, 8'h04, 8'h03);
        t_org(6'h00, 8'h20, 1'b1);
        t_org(6'h01, 8'h20, 1'b0);
        t_rows();
        tally_and_finish();
    end
endmodule : ctlrr_timing_test
`default_nettype wire
